// >>> core/see_pkg.sv
// constants, types and state layout of the serial eeprom command block
package see_pkg;
   localparam int          ADDR_W      = 9;
   localparam int          MEM_BYTES   = 1 << ADDR_W;
   localparam int          PAGE_BITS   = 4;
   localparam int          FIFO_DEPTH  = 16;
   // opcode fields: upper nibble zero, low three bits select the command
   localparam logic [3:0]  OPC_HI      = 4'h0;
   localparam logic [2:0]  CMD_WRITE_ENABLE  = 3'h6;
   localparam logic [2:0]  CMD_WRITE_DISABLE = 3'h4;
   localparam logic [2:0]  CMD_STATUS_READ   = 3'h5;
   localparam logic [2:0]  CMD_STATUS_WRITE  = 3'h1;
   localparam logic [2:0]  CMD_MEM_READ      = 3'h3;
   localparam logic [2:0]  CMD_MEM_WRITE     = 3'h2;
   localparam int          OPC_ADDR_BIT      = 3;
   // status byte layout and values
   localparam logic [3:0]  STAT_UNUSED = 4'hF;
   localparam logic [1:0]  BP_RESET    = 2'h0;
   localparam logic [1:0]  BP_NONE     = 2'h0;
   localparam logic [1:0]  BP_QUARTER  = 2'h1;
   localparam logic [1:0]  BP_HALF     = 2'h2;
   localparam int          STAT_BP_LSB = 2;
   localparam logic [7:0]  MEM_ERASED  = 8'hFF;
   // frame counting
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [2:0]  BIT_FIRST   = 3'h0;
   localparam logic [4:0]  BYTES_OPC   = 5'h01;
   localparam logic [4:0]  BYTES_STAT  = 5'h02;
   localparam logic [4:0]  BYTES_DATA1 = 5'h03;
   localparam logic [4:0]  BYTES_MAX   = 5'h1F;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_OPC       = 4'h1,
      ST_ADDR      = 4'h2,
      ST_DATA_IN   = 4'h3,
      ST_RD_OUT    = 4'h4,
      ST_STAT_OUT  = 4'h5,
      ST_STAT_IN   = 4'h6,
      ST_STAT_DONE = 4'h7,
      ST_CMD_WRITE_ENABLE_END  = 4'h8,
      ST_CMD_WRITE_DISABLE_END  = 4'h9,
      ST_IGNORE    = 4'hA
   } see_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } see_wr_t;

   typedef struct packed {
      logic [1:0]        cs_s;
      logic [1:0]        sck_s;
      logic [1:0]        si_s;
      logic [1:0]        wp_s;
      logic              cs_q;
      logic              sck_q;
      see_state_t        state;
      logic [2:0]        bit_cnt;
      logic [4:0]        byte_cnt;
      logic [7:0]        sh;
      logic [7:0]        out_sh;
      logic [ADDR_W-1:0] addr;
      logic              is_read;
      logic [1:0]        bp;
      logic              write_enable_latch;
      logic              busy;
      logic              cmd_status_write_pend;
      logic [1:0]        cmd_status_write_val;
      logic              so;
      logic              so_oe;
   } see_regs_t;
endpackage

// >>> core/see_eeprom.sv
// serial eeprom command decoder, status byte, write buffer and array
`timescale 1ns/1ps
`default_nettype none

// write buffer: count based fifo with flush
module see_fifo #(
   parameter int W = 17,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         flush,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } see_fifo_ptr_t;

   see_fifo_ptr_t r_r;
   see_fifo_ptr_t r_nxt;
   logic [W-1:0]  mem [D];
   logic          push;
   logic          pop;

   assign in_ready  = (r_r.cnt != (AW+1)'(D));
   assign out_valid = (r_r.cnt != '0);
   assign out_data  = mem[r_r.rp];
   assign push      = in_valid & in_ready & ~flush;
   assign pop       = out_valid & out_ready & ~flush;

   // pointer update
   always_comb begin
      r_nxt = r_r;
      if (flush) begin
         r_nxt = '0;
      end else begin
         if (push) r_nxt.wp = r_r.wp + 1'b1;
         if (pop) r_nxt.rp = r_r.rp + 1'b1;
         if (push & ~pop) r_nxt.cnt = r_r.cnt + 1'b1;
         if (pop & ~push) r_nxt.cnt = r_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[r_r.wp] <= in_data;
      end
   end
endmodule

module see_eeprom (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // serial bus pins
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic wp_n,
   output logic      so,
   output logic      so_oe
);
   localparam int AW = see_pkg::ADDR_W;

   see_pkg::see_regs_t r_r;
   see_pkg::see_regs_t r_nxt;
   logic [7:0]         mem [see_pkg::MEM_BYTES];
   logic               sel;
   logic               sck_rise;
   logic               sck_fall;
   logic               cs_fall;
   logic               cs_rise;
   logic [7:0]         in_byte;
   logic [7:0]         status;
   logic [AW-1:0]      addr_new;
   logic               push_valid;
   logic               push_ready;
   logic               pop_valid;
   logic               flush;
   see_pkg::see_wr_t   push_data;
   see_pkg::see_wr_t   pop_data;

   // protected area from block protect bits
   function automatic logic prot(input logic [AW-1:0] a, input logic [1:0] bp);
      logic res;
      res = 1'b1;
      unique case (bp)
         see_pkg::BP_NONE:    res = 1'b0;
         see_pkg::BP_QUARTER: res = &a[AW-1 -: 2];
         see_pkg::BP_HALF:    res = a[AW-1];
         default:             res = 1'b1;
      endcase
      return res;
   endfunction

   // as shipped every byte reads erased
   initial begin
      for (int i = 0; i < see_pkg::MEM_BYTES; i++) begin
         mem[i] = see_pkg::MEM_ERASED;
      end
   end

   // edges of the synchronised pins
   assign sel      = ~r_r.cs_s[1];
   assign sck_rise = r_r.sck_s[1] & ~r_r.sck_q;
   assign sck_fall = ~r_r.sck_s[1] & r_r.sck_q;
   assign cs_fall  = ~r_r.cs_s[1] & r_r.cs_q;
   assign cs_rise  = r_r.cs_s[1] & ~r_r.cs_q;
   assign in_byte  = {r_r.sh[6:0], r_r.si_s[1]};
   assign status   = {see_pkg::STAT_UNUSED, r_r.bp, r_r.write_enable_latch, r_r.busy};
   assign addr_new = AW'({r_r.addr[AW-1], in_byte});
   assign push_data = '{addr: r_r.addr, data: in_byte};

   // command decode, shifting and write control
   always_comb begin
      r_nxt      = r_r;
      push_valid = 1'b0;
      flush      = 1'b0;
      r_nxt.cs_s  = {r_r.cs_s[0], cs_n};
      r_nxt.sck_s = {r_r.sck_s[0], sck};
      r_nxt.si_s  = {r_r.si_s[0], si};
      r_nxt.wp_s  = {r_r.wp_s[0], wp_n};
      r_nxt.cs_q  = r_r.cs_s[1];
      r_nxt.sck_q = r_r.sck_s[1];
      // internal write ends once the buffer has drained
      if (r_r.busy && !pop_valid) begin
         if (r_r.cmd_status_write_pend) r_nxt.bp = r_r.cmd_status_write_val;
         r_nxt.cmd_status_write_pend = 1'b0;
         r_nxt.busy      = 1'b0;
         r_nxt.write_enable_latch       = 1'b0;
      end
      if (cs_fall) begin
         r_nxt.state    = see_pkg::ST_OPC;
         r_nxt.bit_cnt  = see_pkg::BIT_FIRST;
         r_nxt.byte_cnt = '0;
         r_nxt.sh       = '0;
      end else if (cs_rise) begin
         // frame end decides whether the command takes effect
         unique case (r_r.state)
            see_pkg::ST_CMD_WRITE_ENABLE_END: r_nxt.write_enable_latch = 1'b1;
            see_pkg::ST_CMD_WRITE_DISABLE_END: r_nxt.write_enable_latch = 1'b0;
            see_pkg::ST_STAT_DONE: begin
               if (r_r.wp_s[1]) begin
                  r_nxt.busy      = 1'b1;
                  r_nxt.cmd_status_write_pend = 1'b1;
               end
            end
            see_pkg::ST_DATA_IN: begin
               if (r_r.bit_cnt == see_pkg::BIT_FIRST && r_r.wp_s[1]
                   && r_r.byte_cnt >= see_pkg::BYTES_DATA1) begin
                  r_nxt.busy = 1'b1;
               end else begin
                  flush = 1'b1; // cancelled frame
               end
            end
            default: flush = 1'b0;
         endcase
         r_nxt.state = see_pkg::ST_IDLE;
      end else if (sel && sck_rise) begin
         r_nxt.sh      = in_byte;
         r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
         if (r_r.bit_cnt == see_pkg::BIT_LAST) begin
            if (r_r.byte_cnt != see_pkg::BYTES_MAX) begin
               r_nxt.byte_cnt = r_r.byte_cnt + 5'h01;
            end
            unique case (r_r.state)
               see_pkg::ST_OPC: begin
                  r_nxt.addr[AW-1] = in_byte[see_pkg::OPC_ADDR_BIT];
                  r_nxt.state = see_pkg::ST_IGNORE;
                  if (in_byte[7:4] == see_pkg::OPC_HI) begin
                     unique case (in_byte[2:0])
                        see_pkg::CMD_STATUS_READ: begin
                           r_nxt.state  = see_pkg::ST_STAT_OUT;
                           r_nxt.out_sh = status;
                        end
                        see_pkg::CMD_WRITE_ENABLE:
                           if (!r_r.busy) r_nxt.state = see_pkg::ST_CMD_WRITE_ENABLE_END;
                        see_pkg::CMD_WRITE_DISABLE:
                           if (!r_r.busy) r_nxt.state = see_pkg::ST_CMD_WRITE_DISABLE_END;
                        see_pkg::CMD_STATUS_WRITE:
                           if (!r_r.busy && r_r.write_enable_latch && r_r.wp_s[1]) begin
                              r_nxt.state = see_pkg::ST_STAT_IN;
                           end
                        see_pkg::CMD_MEM_READ:
                           if (!r_r.busy) begin
                              r_nxt.state   = see_pkg::ST_ADDR;
                              r_nxt.is_read = 1'b1;
                           end
                        see_pkg::CMD_MEM_WRITE:
                           if (!r_r.busy && r_r.write_enable_latch && r_r.wp_s[1]) begin
                              r_nxt.state   = see_pkg::ST_ADDR;
                              r_nxt.is_read = 1'b0;
                           end
                        default: r_nxt.state = see_pkg::ST_IGNORE;
                     endcase
                  end
               end
               see_pkg::ST_ADDR: begin
                  r_nxt.addr = addr_new;
                  if (r_r.is_read) begin
                     r_nxt.state  = see_pkg::ST_RD_OUT;
                     r_nxt.out_sh = mem[addr_new];
                  end else begin
                     r_nxt.state = see_pkg::ST_DATA_IN;
                  end
               end
               see_pkg::ST_RD_OUT: begin
                  r_nxt.addr   = r_r.addr + 1'b1;
                  r_nxt.out_sh = mem[AW'(r_r.addr + 1'b1)];
               end
               see_pkg::ST_STAT_OUT: r_nxt.out_sh = status;
               see_pkg::ST_STAT_IN: begin
                  r_nxt.cmd_status_write_val = in_byte[see_pkg::STAT_BP_LSB +: 2];
                  r_nxt.state    = see_pkg::ST_STAT_DONE;
               end
               see_pkg::ST_DATA_IN: begin
                  push_valid = 1'b1;
                  if (push_ready) begin
                     r_nxt.addr[see_pkg::PAGE_BITS-1:0] =
                        r_r.addr[see_pkg::PAGE_BITS-1:0] + 1'b1;
                  end
               end
               see_pkg::ST_STAT_DONE: r_nxt.state = see_pkg::ST_IGNORE;
               default: r_nxt.state = r_r.state;
            endcase
         end else if (r_r.state == see_pkg::ST_CMD_WRITE_ENABLE_END
                      || r_r.state == see_pkg::ST_CMD_WRITE_DISABLE_END
                      || r_r.state == see_pkg::ST_STAT_DONE) begin
            r_nxt.state = see_pkg::ST_IGNORE;
         end
      end
      // output changes on the falling edge only
      if (sel && sck_fall && (r_r.state == see_pkg::ST_RD_OUT
                              || r_r.state == see_pkg::ST_STAT_OUT)) begin
         r_nxt.so     = r_r.out_sh[7];
         r_nxt.out_sh = {r_r.out_sh[6:0], 1'b1};
      end
      r_nxt.so_oe = ~r_nxt.cs_q & (r_nxt.state == see_pkg::ST_RD_OUT
                                   || r_nxt.state == see_pkg::ST_STAT_OUT);
      // protect pin low clears the latch
      if (!r_r.wp_s[1]) r_nxt.write_enable_latch = 1'b0;
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_r          <= '0;
         r_r.cs_s     <= 2'h3;
         r_r.cs_q     <= 1'b1;
         r_r.bp       <= see_pkg::BP_RESET;
         r_r.state    <= see_pkg::ST_IDLE;
      end else begin
         r_r <= r_nxt;
      end
   end

   // page buffer between the serial side and the array
   see_fifo #(
      .W ($bits(see_pkg::see_wr_t)),
      .D (see_pkg::FIFO_DEPTH)
   ) i_see_fifo (
      .clk       (clk),
      .rst       (rst),
      .flush     (flush),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (pop_valid),
      .out_ready (r_r.busy),
      .out_data  (pop_data)
   );

   // array write while busy, protected bytes skipped; plain always, image is preloaded
   always @(posedge clk) begin
      if (r_r.busy && pop_valid && !prot(pop_data.addr, r_r.bp)) begin
         mem[pop_data.addr] <= pop_data.data;
      end
   end

   assign so    = r_r.so;
   assign so_oe = r_r.so_oe;
endmodule

`default_nettype wire

// >>> verif/see_eeprom_assertions.sv
// concurrent checks on the serial eeprom pins
`timescale 1ns/1ps
`default_nettype none
module see_eeprom_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial bus pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic wp_n,
   input wire logic so,
   input wire logic so_oe
);
   logic       sck_d;
   logic       sck_rise;
   logic       bad_opc;
   logic       rd_stat;
   logic [5:0] rise_cnt;
   logic [7:0] opc;
   logic [3:0] fall_age;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // opcode decode from the pins
   assign sck_rise = sck && !sck_d;
   assign bad_opc  = opc[7:4] != 4'h0 || opc[2:0] == 3'h0 || opc[2:0] == 3'h7;
   assign rd_stat  = opc[7:4] == 4'h0 && opc[2:0] == 3'h5;

   // frame tracking: rises, opcode bits, age of last fall
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_d    <= 1'b0;
         rise_cnt <= 6'h00;
         opc      <= 8'h00;
         fall_age <= 4'hF;
      end else begin
         sck_d <= sck;
         if (sck_d && !sck) begin
            fall_age <= 4'h0;
         end else if (fall_age != 4'hF) begin
            fall_age <= fall_age + 4'h1;
         end
         if (cs_n) begin
            rise_cnt <= 6'h00;
         end else if (sck_rise && rise_cnt != 6'h3F) begin
            rise_cnt <= rise_cnt + 6'h01;
         end
         if (sck_rise && !cs_n && rise_cnt < 6'h08) begin
            opc <= {opc[6:0], si};
         end
      end
   end

   oe_idle_a: assert property (cs_n [*6] |-> !so_oe)
      else $error("output enabled while deselected");
   oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
      else $error("output not released after deselect");
   oe_reset_a: assert property ($fell(rst) |-> !so_oe)
      else $error("output enabled out of reset");
   so_fall_a: assert property ($changed(so) && so_oe && $past(so_oe) |-> fall_age <= 4'h5)
      else $error("output changed away from a clock fall");
   oe_after_opc_a: assert property ($rose(so_oe) |-> rise_cnt >= 6'h08 && !bad_opc)
      else $error("output enabled before a valid opcode");
   bad_opc_a: assert property (!cs_n && rise_cnt >= 6'h08 && bad_opc |-> !so_oe)
      else $error("output enabled after unknown opcode");
   stat_oe_a: assert property (sck_rise && !cs_n && rd_stat && rise_cnt >= 6'h08 |-> so_oe)
      else $error("status byte not driven");
   stat_ones_a: assert property (sck_rise && !cs_n && rd_stat && rise_cnt >= 6'h08
                                 && rise_cnt[2] == 1'b0 |-> so)
      else $error("unused status bit not one");

   // main scenarios reached
   cover property (sck_rise && rd_stat && rise_cnt == 6'h10);
   cover property ($rose(so_oe) && rise_cnt >= 6'h10);
   cover property (!cs_n && bad_opc && rise_cnt == 6'h08);
endmodule
bind see_eeprom see_eeprom_checker i_see_eeprom_checker (.clk(clk), .rst(rst), .cs_n(cs_n),
   .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));
`default_nettype wire

// >>> verif/see_host.sv
// host serial master model facing the eeprom pins
`timescale 1ns/1ps
`default_nettype none
module see_host (
   // serial bus pins
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   logic last_so;

   // idle: deselected, link clock standing low
   initial begin
      cs_n    = 1'b1;
      sck     = 1'b0;
      si      = 1'b0;
      last_so = 1'b0;
   end

   // one frame, msb first; a floating output reads as changing
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      #3.1 cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si = tx[i];
         #62.5 sck = 1'b1;
         last_so = so_oe ? so : ~last_so;
         rx = {rx[30:0], last_so};
         #62.5 sck = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      si = ~si;
      #200;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_see_eeprom.sv
// self-checking bench of the serial eeprom command block
`timescale 1ns/1ps
`default_nettype none
module tb_see_eeprom;
   logic        clk;
   logic        rst;
   logic        cs_n;
   logic        sck;
   logic        si;
   logic        wp_n;
   logic        so;
   logic        so_oe;
   int          oe_cnt = 0;
   logic [31:0] rx;
   int          fails;
   int          checks_done;

   // clock and output-enable watch
   initial clk = 1'b0;
   always #2 clk = ~clk;
   always @(posedge clk) if (so_oe === 1'b1) oe_cnt <= oe_cnt + 1;

   see_eeprom i_see_eeprom (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
      .wp_n(wp_n), .so(so), .so_oe(so_oe));
   see_host i_see_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

   // compare and verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // frame helpers
   task automatic go(input logic [31:0] tx, input int n);
      i_see_host.xfer(tx, n, rx);
   endtask
   task automatic stat(input logic [7:0] exp);
      go(32'h00050000, 24);
      check(rx[15:0], {exp, exp});
   endtask
   task automatic cmd_write_enable;
      go(32'h00000006, 8);
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d, input int n);
      go({4'h0, a[8], 3'h2, a[7:0], d} >> (32 - n), n);
   endtask
   task automatic rd(input logic [8:0] a);
      go({4'h0, a[8], 3'h3, a[7:0], 16'h0000}, 32);
   endtask

   // scenarios
   task automatic t_power;
      stat(8'hF0);
      rd(9'h000);
      check(rx[15:0], 16'hFFFF);
      $display("test power-up done");
   endtask
   task automatic t_latch;
      cmd_write_enable;
      stat(8'hF2);
      go(32'h00000004, 7);
      stat(8'hF2);
      go(32'h00000004, 8);
      stat(8'hF0);
      go(32'h0000000C, 9);
      stat(8'hF0);
      go(32'h00000000, 5);
      go(32'h000D0000, 24);
      check(rx[15:0], 16'hF0F0);
      $display("test latch done");
   endtask
   task automatic t_mem;
      wr(9'h1A5, 16'h3C00, 24);
      rd(9'h1A5);
      check(rx[15:0], 16'hFFFF);
      cmd_write_enable;
      wr(9'h1A5, 16'h3CC3, 32);
      stat(8'hF0);
      rd(9'h1A5);
      check(rx[15:0], 16'h3CC3);
      rd(9'h0A5);
      check(rx[15:0], 16'hFFFF);
      rd(9'h1A6);
      check(rx[15:0], 16'hC3FF);
      $display("test memory done");
   endtask
   task automatic t_prot;
      go(32'h0000010C, 16);
      stat(8'hF0);
      cmd_write_enable;
      go(32'h00000104, 16);
      stat(8'hF4);
      cmd_write_enable;
      wr(9'h1C0, 16'h5500, 24);
      rd(9'h1C0);
      check(rx[15:0], 16'hFFFF);
      cmd_write_enable;
      wr(9'h010, 16'h5500, 24);
      rd(9'h010);
      check(rx[15:0], 16'h55FF);
      cmd_write_enable;
      go(32'h00000200, 17);
      stat(8'hF6);
      go(32'h00000100, 16);
      stat(8'hF0);
      $display("test protect done");
   endtask
   task automatic t_wp;
      cmd_write_enable;
      stat(8'hF2);
      @(negedge clk) wp_n = 1'b0;
      repeat (8) @(negedge clk);
      wp_n = 1'b1;
      stat(8'hF0);
      cmd_write_enable;
      @(negedge clk) wp_n = 1'b0;
      go(32'h00000108, 16);
      @(negedge clk) wp_n = 1'b1;
      stat(8'hF0);
      cmd_write_enable;
      @(negedge clk) rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      stat(8'hF0);
      $display("test write protect done");
   endtask
   task automatic t_bad;
      logic [7:0] bad [5] = '{8'h00, 8'h07, 8'h85, 8'h45, 8'hFF};
      int         n0;
      foreach (bad[i]) begin
         n0 = oe_cnt;
         go({8'h00, bad[i], 16'h0500}, 24);
         check(16'(oe_cnt - n0), 16'h0000);
      end
      stat(8'hF0);
      $display("test unknown opcode done");
   endtask

   // main sequence
   initial begin
      rst         = 1'b1;
      wp_n        = 1'b1;
      fails       = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (4) @(negedge clk);
      t_power;
      t_latch;
      t_mem;
      t_prot;
      t_wp;
      t_bad;
      print_verdict;
   end

   // watchdog
   initial begin
      #300000;
      fails++;
      print_verdict;
   end
endmodule
`default_nettype wire
